// File: verilog/pic_top.sv
/*
  Prioritized interrupt controller: external pin sources with selectable
  pins and sensitivity, latched peripheral requests, fixed priority,
  vector selection, the non-maskable trap, the global mask bit and the
  low power wake-up decision.
  Assumes the core signals instruction boundaries, trap execution and
  stacking completion as one-cycle pulses on pclk, and that the power
  sequencer reports the current low power mode. Pins are synchronous.
*/
`timescale 1ns/1ps
module pic_top
  import pic_pkg::*;
(
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Port pins and their interrupt enables
  input wire logic [7:0] port_a_in,
  input wire logic [7:0] port_b_in,
  input wire logic [7:0] port_a_int_en,
  input wire logic [7:0] port_b_int_en,
  // Peripheral flags: bit 0 is source 0, bits 9:1 are sources 13:5
  input wire logic [NPER-1:0] periph_flag,
  input wire logic [NPER-1:0] periph_ie,
  input wire logic [NPER-1:0] periph_clear,
  // Core side
  input wire logic cpu_insn_end,
  input wire logic cpu_trap,
  input wire logic cpu_save_done,
  input wire logic cpu_mask_set,
  input wire logic cpu_mask_clr,
  input wire logic [3:0] lp_mode,
  output logic mask_bit,
  output logic save_req,
  output logic vec_load,
  output logic [15:0] vec_addr,
  output logic wake
);

  typedef struct packed {
    logic [7:0] sens;
    logic [7:0] pinsel;
    logic i_bit;
    logic [NEXT-1:0] lvl;
    logic [NEXT-1:0] ext_latch;
    logic [NPER-1:0] per_prev;
    logic [NPER-1:0] per_pend;
    pic_state_t state;
    logic svc_trap;
    logic [3:0] svc_idx;
    logic save_req;
    logic vec_load;
    logic [15:0] vec_addr;
    logic wake;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } pic_regs_t;

  pic_regs_t r_ff;
  pic_regs_t nxt_r;

  logic [NEXT-1:0] ext_level;
  logic [NEXT-1:0] ext_edge;
  logic [NEXT-1:0] ext_low_req;
  logic [NSRC-1:0] pend_all;
  logic [NSRC-1:0] en_all;
  logic [NSRC-1:0] elig;
  logic [NSRC-1:0] wake_mask;
  logic [NPER-1:0] per_rise;
  logic [3:0] win_idx;
  logic win_any;
  logic setup_ph;
  logic access_ph;
  logic addr_ok;
  logic [7:0] grp_mask;
  logic [7:0] sel_mask;
  logic [7:0] pins;
  logic [7:0] pin_ie;
  logic [1:0] fld;
  logic [1:0] code;

  // Pin selection and the AND-combined source level per external source
  always_comb begin
    grp_mask = 8'h00;
    sel_mask = 8'h00;
    pins = 8'h00;
    pin_ie = 8'h00;
    fld = PIN_NONE;
    code = SENS_FALL_LOW;
    ext_level = '1;
    ext_edge = '0;
    ext_low_req = '0;
    for (int e = 0; e < NEXT; e++) begin
      fld = r_ff.pinsel[e*FLD_W +: FLD_W];
      code = r_ff.sens[e*FLD_W +: FLD_W];
      pins = SRC_ON_PB[e] ? port_b_in : port_a_in;
      pin_ie = SRC_ON_PB[e] ? port_b_int_en : port_a_int_en;
      grp_mask = 8'h00;
      sel_mask = 8'h00;
      for (int k = 0; k < 3; k++) begin
        grp_mask[PIN_IDX[e][k]] = 1'b1;
      end
      if (fld != PIN_NONE) begin
        sel_mask[PIN_IDX[e][fld - 2'h1]] = 1'b1;
      end
      // combined pin level
      // A source with no pin selected idles high; deselecting a low level can still latch a rising edge.
      if (fld == PIN_NONE) begin
        ext_level[e] = 1'b1;
      end else begin
        ext_level[e] = &(pins | ~((pin_ie & grp_mask) | sel_mask));
      end
      unique case (code)
        SENS_RISE: ext_edge[e] = ext_level[e] & ~r_ff.lvl[e];
        SENS_FALL: ext_edge[e] = ~ext_level[e] & r_ff.lvl[e];
        SENS_BOTH: ext_edge[e] = ext_level[e] ^ r_ff.lvl[e];
        SENS_FALL_LOW: ext_edge[e] = ~ext_level[e] & r_ff.lvl[e];
      endcase
      ext_low_req[e] = (code == SENS_FALL_LOW) & ~ext_level[e];
    end
  end

  // Request, enable and eligibility vectors in source order
  always_comb begin
    per_rise = periph_flag & ~r_ff.per_prev;
    pend_all = {r_ff.per_pend[NPER-1:1],
                r_ff.ext_latch | ext_low_req,
                r_ff.per_pend[0]};
    en_all = {periph_ie[NPER-1:1], {NEXT{1'b1}}, periph_ie[0]};
    // external needs event and clear mask
    elig = pend_all & en_all & {NSRC{~r_ff.i_bit}};
  end

  always_comb begin
    win_idx = 4'h0;
    win_any = 1'b0;
    for (int s = NSRC - 1; s >= 0; s--) begin
      if (elig[s]) begin
        win_idx = 4'(s);
        win_any = 1'b1;
      end
    end
  end

  // Wake-up mask for the current low power mode
  always_comb begin
    unique case (lp_mode)
      LP_WAIT: wake_mask = WAKE_WAIT;
      LP_HALT: wake_mask = WAKE_HALT;
      LP_AHALT: wake_mask = WAKE_AHALT;
      LP_AWU: wake_mask = WAKE_AWU;
      default: wake_mask = '0;
    endcase
  end

  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable & r_ff.pready;
  assign addr_ok = (paddr == OFS_SENS) | (paddr == OFS_PINSEL) |
                   (paddr == OFS_STATUS);

  // Next-state logic for the whole block
  always_comb begin
    nxt_r = r_ff;
    nxt_r.lvl = ext_level;
    nxt_r.per_prev = periph_flag;
    nxt_r.vec_load = 1'b0;

    // Mask bit: core instructions first, entry sequence overrides below
    if (cpu_mask_set) begin
      nxt_r.i_bit = 1'b1;
    end else if (cpu_mask_clr) begin
      nxt_r.i_bit = 1'b0;
    end

    // clear pulse from the flag logic
    // A fresh flag edge in the same cycle is kept, not lost.
    nxt_r.per_pend = (r_ff.per_pend & ~periph_clear) | per_rise;

    nxt_r.ext_latch = r_ff.ext_latch | ext_edge;

    // Low power wake decision ignores the mask; the mode entry clears it
    nxt_r.wake = |(pend_all & en_all & wake_mask);

    // Service sequencer
    unique case (r_ff.state)
      ST_IDLE: begin
        if (cpu_trap) begin
          nxt_r.svc_trap = 1'b1;
          nxt_r.state = ST_SAVE;
          nxt_r.save_req = 1'b1;
        end else if (cpu_insn_end && win_any) begin
          nxt_r.svc_trap = 1'b0;
          nxt_r.svc_idx = win_idx;
          nxt_r.state = ST_SAVE;
          nxt_r.save_req = 1'b1;
          if (win_idx >= 4'(EXT_BASE) && win_idx < 4'(EXT_BASE + NEXT)) begin
            nxt_r.ext_latch[2'(win_idx - 4'(EXT_BASE))] =
              ext_edge[2'(win_idx - 4'(EXT_BASE))];
          end
        end
      end
      ST_SAVE: begin
        if (cpu_save_done) begin
          nxt_r.save_req = 1'b0;
          nxt_r.state = ST_MASK;
        end
      end
      ST_MASK: begin
        nxt_r.i_bit = 1'b1;
        nxt_r.state = ST_LOAD;
        nxt_r.vec_load = 1'b1;
        if (r_ff.svc_trap) begin
          nxt_r.vec_addr = VEC_TRAP;
        end else begin
          nxt_r.vec_addr = VEC_SRC0 - 16'(r_ff.svc_idx) * VEC_STEP;
        end
      end
      ST_LOAD: begin
        nxt_r.state = ST_IDLE;
      end
      default: begin
        nxt_r.state = ST_IDLE;
        nxt_r.save_req = 1'b0;
      end
    endcase

    // APB: setup cycle prepares the answer, access cycle completes it
    if (setup_ph && !r_ff.pready) begin
      nxt_r.pready = 1'b1;
      nxt_r.pslverr = ~addr_ok;
      nxt_r.prdata = '0;
      if (!pwrite) begin
        unique case (paddr)
          OFS_SENS: nxt_r.prdata[7:0] = r_ff.sens;
          OFS_PINSEL: nxt_r.prdata[7:0] = r_ff.pinsel;
          OFS_STATUS: begin
            nxt_r.prdata[NSRC-1:0] = pend_all;
            nxt_r.prdata[STAT_MASK_BIT] = r_ff.i_bit;
            nxt_r.prdata[STAT_BUSY_BIT] = (r_ff.state != ST_IDLE);
          end
          default: nxt_r.prdata = '0;
        endcase
      end
    end else if (access_ph) begin
      nxt_r.pready = 1'b0;
      nxt_r.pslverr = 1'b0;
      if (pwrite) begin
        if (paddr == OFS_SENS && r_ff.i_bit) begin
          nxt_r.sens = pwdata[7:0];
        end
        if (paddr == OFS_PINSEL) begin
          nxt_r.pinsel = pwdata[7:0];
        end
      end
    end else begin
      nxt_r.pready = 1'b0;
      nxt_r.pslverr = 1'b0;
    end
  end

  // State register; clock enable low freezes everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_ff.sens <= SENS_RST;
      r_ff.pinsel <= PINSEL_RST;
      r_ff.i_bit <= 1'b1;
      r_ff.lvl <= '1;
      r_ff.ext_latch <= '0;
      r_ff.per_prev <= '0;
      r_ff.per_pend <= '0;
      r_ff.state <= ST_IDLE;
      r_ff.svc_trap <= 1'b0;
      r_ff.svc_idx <= 4'h0;
      r_ff.save_req <= 1'b0;
      r_ff.vec_load <= 1'b0;
      r_ff.vec_addr <= VEC_RESET;
      r_ff.wake <= 1'b0;
      r_ff.prdata <= '0;
      r_ff.pready <= 1'b0;
      r_ff.pslverr <= 1'b0;
    end else if (clk_en) begin
      r_ff <= nxt_r;
    end
  end

  // Outputs straight from the state register
  assign prdata = r_ff.prdata;
  assign pready = r_ff.pready;
  assign pslverr = r_ff.pslverr;
  assign mask_bit = r_ff.i_bit;
  assign save_req = r_ff.save_req;
  assign vec_load = r_ff.vec_load;
  assign vec_addr = r_ff.vec_addr;
  assign wake = r_ff.wake;

endmodule

// File: verilog/pic_pkg.sv
/*
  Constants shared by the prioritized interrupt controller: register map,
  field layout, reset values, vector addresses, wake-up masks, FSM codes.
  Assumes an APB master with 32-bit data and an 8-bit byte address.
*/
// Notes on behaviour
// - Entering a service routine sets the global mask bit.
// - Simultaneous enabled requests: lowest source index is served first.
// - Vectors: reset FFFE, trap FFFC, sources 0..13 from FFFA down to FFE0.
// - Any interrupt source wakes the core from wait mode.
// - Halt ends only on reset, external sources, serial peripheral, marked ones.
// - Reload overflow and timer real-time 1 wake from active-halt only.
// - Auto-wake-up source ends only auto-wake-up-from-halt mode and wait mode.
// - Trap instruction is always serviced whatever the mask bit.
// - External vector loads only after its event and with mask clear.
// - Edge request latched until service entry clears it.
// - Sensitivity acts on the AND-combined enabled pins; low blocks rising.
// - Peripheral request needs mask clear and enable set, else stays pending.
// - The flag-clearing sequence also discards the pending latch.
// - Sensitivity register: four 2-bit fields, source 3 at top, reset 00h.
// - Sensitivity writes take effect only while the mask bit is set.
// - Codes: 00 fall+low, 01 rise, 10 fall, 11 both edges.
// - Source 3 pin: none, port B bits 0, 1, 2; resets to none.
// - Source 2 pin: none, port B bits 3, 5, 6; resets to none.
// - Source 1 pin: none, port A bits 4, 5, 6; resets to none.
// - Source 0 pin select is software writable, bits 1:0.
// - Source 0 pin: none, port A bits 1, 2, 3; resets to none.
// - Entry: stack the context, then set the mask, then load vector; here mask set and vector load come on the same edge.
// - After reset all maskable interrupts stay disabled until mask clear.
package pic_pkg;

  // Bus and register map
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFS_SENS = 8'h00;
  localparam logic [7:0] OFS_PINSEL = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] SENS_RST = 8'h00;
  localparam logic [7:0] PINSEL_RST = 8'h00;
  localparam int STAT_MASK_BIT = 16;
  localparam int STAT_BUSY_BIT = 17;

  // Sources
  localparam int NSRC = 14;
  localparam int NEXT = 4;
  localparam int NPER = 10;
  localparam int EXT_BASE = 1;
  localparam int FLD_W = 2;
  localparam logic [1:0] PIN_NONE = 2'h0;

  // Sensitivity codes
  localparam logic [1:0] SENS_FALL_LOW = 2'h0;
  localparam logic [1:0] SENS_RISE = 2'h1;
  localparam logic [1:0] SENS_FALL = 2'h2;
  localparam logic [1:0] SENS_BOTH = 2'h3;

  // Pin map per external source, codes 1..3 in order; sources 2,3 on port B
  localparam logic [NEXT-1:0] SRC_ON_PB = 4'hC;
  localparam logic [NEXT-1:0][2:0][2:0] PIN_IDX = '{
    '{3'h2, 3'h1, 3'h0},
    '{3'h6, 3'h5, 3'h3},
    '{3'h6, 3'h5, 3'h4},
    '{3'h3, 3'h2, 3'h1}};

  // Vectors
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_TRAP = 16'hFFFC;
  localparam logic [15:0] VEC_SRC0 = 16'hFFFA;
  localparam logic [15:0] VEC_STEP = 16'h0002;

  // Low power modes as driven by the power sequencer
  localparam logic [3:0] LP_RUN = 4'h0;
  localparam logic [3:0] LP_WAIT = 4'h1;
  localparam logic [3:0] LP_HALT = 4'h2;
  localparam logic [3:0] LP_AHALT = 4'h4;
  localparam logic [3:0] LP_AWU = 4'h8;

  // Wake-up source masks per mode
  localparam logic [NSRC-1:0] WAKE_WAIT = 14'h3FFF;
  localparam logic [NSRC-1:0] WAKE_HALT = 14'h101E;
  localparam logic [NSRC-1:0] WAKE_AHALT = 14'h1A1E;
  localparam logic [NSRC-1:0] WAKE_AWU = 14'h101F;

  // Service sequencer
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SAVE = 4'b0010,
    ST_MASK = 4'b0100,
    ST_LOAD = 4'b1000
  } pic_state_t;

endpackage

// File: verification/pic_assertions.sv
/* Checker for the interrupt controller's service and bus outputs.
   Bound into pic_top; sees only that module's ports. */
`timescale 1ns/1ps
module pic_assertions
  import pic_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus answer
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Core handshake
  input wire logic cpu_insn_end,
  input wire logic cpu_trap,
  input wire logic cpu_save_done,
  input wire logic mask_bit,
  input wire logic save_req,
  input wire logic vec_load,
  input wire logic [15:0] vec_addr
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Entry is two steps: stacking done, then mask and vector together
  sequence s_saved;
    save_req && cpu_save_done;
  endsequence
  sequence s_entry;
    mask_bit && vec_load;
  endsequence
  a_entry_order: assert property (s_saved |-> ##[1:2] s_entry)
    else $error("vector load missing after stacking");
  a_mask_on_load: assert property (vec_load |-> mask_bit)
    else $error("mask clear at vector load");
  a_load_pulse: assert property (
    vec_load |=> !vec_load && !save_req)
    else $error("vector load longer than one cycle");
  a_save_holds: assert property (
    save_req && !cpu_save_done |=> save_req)
    else $error("stacking request dropped early");
  a_save_cause: assert property (
    $rose(save_req) |-> $past(cpu_trap) || $past(cpu_insn_end))
    else $error("service started without a cause");
  a_reset_masked: assert property (
    $rose(presetn) |-> mask_bit && !save_req)
    else $error("mask clear after reset");
  a_vec_range: assert property (vec_load |-> vec_addr == VEC_TRAP ||
    vec_addr inside {[16'hFFE0:VEC_SRC0]} && !vec_addr[0])
    else $error("vector outside the table");
  a_vec_held: assert property ($changed(vec_addr) |-> vec_load)
    else $error("vector moved without a load");
  a_bus_answer: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("bus answer not one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule
bind pic_top pic_assertions pic_assertions_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .cpu_insn_end(cpu_insn_end), .cpu_trap(cpu_trap),
  .cpu_save_done(cpu_save_done), .mask_bit(mask_bit),
  .save_req(save_req), .vec_load(vec_load), .vec_addr(vec_addr));

// File: verification/pic_core_model.sv
/* Core partner: answers each stacking request after a chosen lag.
   Assumes save_req is a level held until the done pulse is seen. */
`timescale 1ns/1ps
module pic_core_model (
  // Clock
  input wire logic pclk,
  // Stacking handshake
  input wire logic save_req,
  input wire logic [3:0] lag,
  output logic cpu_save_done
);
  initial cpu_save_done = 1'b0;
  // context stacking
  // Done pulses once, only while the request stands, so never early
  always @(posedge pclk) begin
    if (save_req && !cpu_save_done) begin
      repeat (lag) @(posedge pclk);
      cpu_save_done <= 1'b1;
      @(posedge pclk);
      cpu_save_done <= 1'b0;
    end
  end
endmodule

// File: verification/tb_top.sv
/* Bench for pic_top: bus, external pins, priority, wake-up, trap.
   Assumes pic_core_model answers stacking; the checker is bound. */
`timescale 1ns/1ps
module tb_top
  import pic_pkg::*;
();
  logic pclk = 1'b0, presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, b;
  logic [31:0] pwdata = 32'h0, prdata, rd, d;
  logic pready, pslverr, err_seen, mask_bit, save_req, vec_load, wake;
  logic done, lo, ce = 1'b1;
  logic [15:0] vec_addr;
  logic [7:0] pa = 8'hFF, pb = 8'hFF, pa_en = 8'h00, pb_en = 8'h00;
  logic [NPER-1:0] flag = '0, ie = '0, fclr = '0;
  logic insn = 1'b0, trap = 1'b0, mset = 1'b0, mclr = 1'b0;
  logic [3:0] lp = LP_RUN, lag = 4'h0;
  logic [1:0] m;
  logic [31:0] seed = 32'hFAB;
  int err_count = 0, checks = 0, cyc = 0, s, c;
  int order[4] = '{0, 5, 11, 13};

  always #4 pclk = ~pclk;
  pic_top pic_top_inst (.pclk(pclk), .presetn(presetn), .clk_en(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_a_in(pa), .port_b_in(pb), .port_a_int_en(pa_en),
    .port_b_int_en(pb_en), .periph_flag(flag), .periph_ie(ie),
    .periph_clear(fclr), .cpu_insn_end(insn), .cpu_trap(trap),
    .cpu_save_done(done), .cpu_mask_set(mset), .cpu_mask_clr(mclr),
    .lp_mode(lp), .mask_bit(mask_bit), .save_req(save_req),
    .vec_load(vec_load), .vec_addr(vec_addr), .wake(wake));
  pic_core_model pic_core_model_inst (.pclk(pclk), .save_req(save_req),
    .lag(lag), .cpu_save_done(done));

  // Xorshift source, fixed start for repeatable runs
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Vector of source i and pin bit of source s under code c
  function automatic logic [15:0] vec(input int i);
    return 16'hFFFA - 16'(2 * i);
  endfunction
  function automatic int pin(input int s, input int c);
    case (s)
      0: return c;
      1: return c + 3;
      2: return (c == 1) ? 3 : c + 3;
      default: return c - 1;
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks=%0d errors=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // One transfer; the request stands until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] v);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer and read data are taken at the edge that sees pready high
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    chk(pready, 1'b1);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic unmask(input logic u);
    @(posedge pclk);
    mclr <= u;
    mset <= !u;
    @(posedge pclk);
    mclr <= 1'b0;
    mset <= 1'b0;
  endtask
  // Start a service at a boundary or by trap, then check the entry
  task automatic serve(input logic t, input logic [15:0] v);
    int n = 0;
    @(posedge pclk);
    lag <= 4'(rnd() % 4);
    trap <= t;
    insn <= !t;
    @(posedge pclk);
    trap <= 1'b0;
    insn <= 1'b0;
    do @(negedge pclk); while (vec_load !== 1'b1 && ++n < 40);
    chk(vec_load, 1'b1);
    chk(vec_addr, v);
    chk(mask_bit, 1'b1);
  endtask
  task automatic pend(input int i, input logic e);
    repeat (3) @(posedge pclk);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[i], e);
  endtask

  // Hang guard: a run far past its expected length fails
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk(mask_bit, 1'b1);
    chk(vec_addr, VEC_RESET);
    // A frozen clock enable must swallow a mask clear pulse
    @(posedge pclk);
    ce <= 1'b0;
    unmask(1'b1);
    ce <= 1'b1;
    chk(mask_bit, 1'b1);
    apb(1'b0, OFS_SENS, 32'h0);
    chk(rd, SENS_RST);
    apb(1'b0, OFS_PINSEL, 32'h0);
    chk(rd, PINSEL_RST);
    apb(1'b0, 8'h0C, 32'h0);
    chk(err_seen, 1'b1);
    // Sensitivity writes land only while masked
    apb(1'b1, OFS_SENS, 32'hAA);
    unmask(1'b1);
    apb(1'b1, OFS_SENS, 32'h55);
    apb(1'b0, OFS_SENS, 32'h0);
    chk(rd, 32'hAA);
    unmask(1'b0);
    repeat (4) begin
      d = rnd();
      apb(1'b1, OFS_PINSEL, d);
      apb(1'b0, OFS_PINSEL, 32'h0);
      chk(rd, {24'h0, d[7:0]});
    end
    apb(1'b1, OFS_SENS, 32'h55);
    apb(1'b1, OFS_PINSEL, 32'h0);
    for (int k = 0; k < 12; k++) begin
      s = k / 3;
      c = k % 3 + 1;
      m = 2'(k % 4);
      lo = (m != SENS_RISE);
      b = 8'(1 << pin(s, c));
      // Codes first, then deselect, so pin moves leave no stale edge
      apb(1'b1, OFS_SENS, 32'(m) << (2 * s));
      apb(1'b1, OFS_PINSEL, 32'h0);
      pa <= {8{lo}};
      pb <= {8{lo}};
      pa_en <= (s < 2) ? b : 8'h00;
      pb_en <= (s < 2) ? 8'h00 : b;
      apb(1'b1, OFS_PINSEL, 32'(c) << (2 * s));
      unmask(1'b1);
      for (int t = 0; t < 2; t++) begin
        @(posedge pclk);
        if (s < 2)
          pa <= pa ^ b;
        else
          pb <= pb ^ b;
        if (t == 0)
          serve(1'b0, vec(s + 1));
        if (t == 0 && m == SENS_FALL_LOW)
          pend(s + 1, 1'b1);
      end
      pend(s + 1, m == SENS_BOTH);
      if (m == SENS_BOTH) begin
        unmask(1'b1);
        serve(1'b0, vec(s + 1));
      end
    end
    // a low enabled pin of the group holds back a rising edge
    apb(1'b1, OFS_SENS, 32'h4);
    pa <= 8'hDF;
    pa_en <= 8'h30;
    apb(1'b1, OFS_PINSEL, 32'h4);
    unmask(1'b1);
    pa <= 8'hCF;
    @(posedge pclk);
    pa <= 8'hDF;
    pend(2, 1'b0);
    pa <= 8'hFF;
    serve(1'b0, vec(2));
    // Four peripheral requests pending while masked
    @(posedge pclk);
    pa_en <= 8'h00;
    pb_en <= 8'h00;
    ie <= 10'h283;
    flag <= 10'h283;
    pend(13, 1'b1);
    for (int j = 0; j < 4; j++) begin
      @(posedge pclk);
      lp <= 4'(1 << j);
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      chk(wake, j != 1);
    end
    @(posedge pclk);
    lp <= LP_RUN;
    for (int j = 0; j < 4; j++) begin
      unmask(1'b1);
      serve(1'b0, vec(order[j]));
      // software clears the served flag before the next one
      @(posedge pclk);
      fclr <= 10'h001 << ((order[j] == 0) ? 0 : order[j] - 4);
      @(posedge pclk);
      fclr <= 10'h000;
    end
    // compare request of the reload timer must not end active-halt
    flag <= 10'h010;
    ie <= 10'h010;
    lp <= LP_AHALT;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk(wake, 1'b0);
    @(posedge pclk);
    lp <= LP_RUN;
    // Disabled request discarded by the clearing sequence
    flag <= 10'h004;
    ie <= 10'h000;
    unmask(1'b1);
    pend(6, 1'b1);
    fclr <= 10'h004;
    @(posedge pclk);
    fclr <= 10'h000;
    ie <= 10'h004;
    pend(6, 1'b0);
    unmask(1'b0);
    serve(1'b1, VEC_TRAP);
    stop_test();
  end
endmodule
